//--- hw/parallel_ports_pkg.sv
// constants shared by the four-port parallel i/o block
// assumes the core issues one-cycle sfr strobes on the same clock
// Behaviour
// - first port latch one: pin released, floating
// - first port latch zero: pin driven low
// - first port is external address/data bus
// - external access loads first port latch ones
// - external access drives first port push-pull while xmem_drive is high
// - write strobe loads port latch from bus
// - read latch returns latch; read pin returns pins
// - second port never drives its pins
// - second port resets analog; zero selects digital
// - third port one pulls high, zero drives low
// - third port outputs upper address in access
// - selected pulse outputs override third port bits
// - third port bit 7 feeds pulse clock
// - third port bits carry spi, timer two
// - fourth port one pulls high, zero drives low
// - fourth port alternate output needs latch one
// - fourth port bits 0, 1 serve uart
// - fourth port bits feed interrupts, timer counts
// - fourth port bits 6, 7 carry memory strobes
// - enabled third port peripheral takes the pin from software
// - read-modify-write reads latch, not pins
package parallel_ports_pkg;
  localparam int PORT_W = 8;
  localparam int NUM_PORTS = 4;
  typedef logic [PORT_W-1:0] port_byte_t;

  // sfr addresses of the port registers
  localparam logic [7:0] FIRST_PORT_ADDR  = 8'h80;
  localparam logic [7:0] SECOND_PORT_ADDR = 8'h90;
  localparam logic [7:0] THIRD_PORT_ADDR  = 8'ha0;
  localparam logic [7:0] FOURTH_PORT_ADDR = 8'hb0;

  localparam port_byte_t LATCH_RESET = 8'hff;
  localparam port_byte_t READ_NONE   = 8'h00;

  // lane indices
  localparam int LANE_FIRST  = 0;
  localparam int LANE_SECOND = 1;
  localparam int LANE_THIRD  = 2;
  localparam int LANE_FOURTH = 3;

  // third port bit positions
  localparam int SPI_SCLK_BIT        = 0;
  localparam int SPI_MOSI_BIT        = 1;
  localparam int SPI_MISO_BIT        = 2;
  localparam int SPI_SS_BIT          = 3;
  localparam int TIMER_TWO_CTRL_BIT  = 4;
  localparam int PWM_A_BIT           = 5;
  localparam int PWM_B_BIT           = 6;
  localparam int PWM_CLK_BIT         = 7;

  // fourth port bit positions
  localparam int UART_RX_BIT         = 0;
  localparam int UART_TX_BIT         = 1;
  localparam int EXT_IRQ_ZERO_BIT    = 2;
  localparam int EXT_IRQ_ONE_BIT     = 3;
  localparam int TIMER_ZERO_CNT_BIT  = 4;
  localparam int TIMER_ONE_CNT_BIT   = 5;
  localparam int XWR_BIT             = 6;
  localparam int XRD_BIT             = 7;
endpackage

//--- hw/port_lane_if.sv
// signals between the port block and one latch/sampler lane
// assumes a single clock domain shared by both ends
`timescale 1ns/1ps
interface port_lane_if
  import parallel_ports_pkg::*;
();
  logic       write_en;
  logic       force_ones;
  port_byte_t write_data;
  port_byte_t latch;
  port_byte_t pin_level;

  modport owner (output write_en, output force_ones, output write_data,
                 input latch, input pin_level);
  modport lane  (input write_en, input force_ones, input write_data,
                 output latch, output pin_level);
endinterface

//--- hw/port_lane.sv
// one port: its bit latch and a two-stage pin synchroniser
// assumes raw pin levels arrive from outside the clock domain
`timescale 1ns/1ps
module port_lane
  import parallel_ports_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // core side
  port_lane_if.lane        bus,
  // raw pin levels
  input  wire parallel_ports_pkg::port_byte_t pin_raw
);
  import parallel_ports_pkg::*;

  port_byte_t pin_meta;

  // latch: external access forcing wins over a software write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus.latch <= LATCH_RESET;
    end else if (bus.force_ones) begin
      bus.latch <= LATCH_RESET;
    end else if (bus.write_en) begin
      bus.latch <= bus.write_data;
    end
  end

  // pins are asynchronous, so two flops before anyone reads them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta      <= READ_NONE;
      bus.pin_level <= READ_NONE;
    end else begin
      pin_meta      <= pin_raw;
      bus.pin_level <= pin_meta;
    end
  end
endmodule

//--- hw/parallel_ports.sv
// four 8-bit parallel ports behind the core's sfr strobes
// assumes the core gives one-cycle strobes and external-access controls
`timescale 1ns/1ps
module parallel_ports
  import parallel_ports_pkg::*;
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  // sfr access from the core
  input  wire logic [7:0]                    sfr_addr,
  input  wire parallel_ports_pkg::port_byte_t sfr_wdata,
  input  wire logic                          sfr_write,
  input  wire logic                          sfr_read_latch,
  input  wire logic                          sfr_read_pin,
  output      parallel_ports_pkg::port_byte_t sfr_rdata,
  // external data memory access from the core
  input  wire logic                          xmem_active,
  input  wire logic                          xmem_drive,
  input  wire parallel_ports_pkg::port_byte_t xmem_addr_data,
  input  wire parallel_ports_pkg::port_byte_t xmem_addr_upper,
  input  wire logic                          xmem_write_strobe_n,
  input  wire logic                          xmem_read_strobe_n,
  // first port pins (open drain / bus)
  input  wire parallel_ports_pkg::port_byte_t first_port_in,
  output      parallel_ports_pkg::port_byte_t first_port_out,
  output      parallel_ports_pkg::port_byte_t first_port_oe,
  output      parallel_ports_pkg::port_byte_t first_port_to_core,
  // second port pins (input only)
  input  wire parallel_ports_pkg::port_byte_t second_port_in,
  output      parallel_ports_pkg::port_byte_t second_port_analog_sel,
  // third port pins (pulled up)
  input  wire parallel_ports_pkg::port_byte_t third_port_in,
  output      parallel_ports_pkg::port_byte_t third_port_out,
  output      parallel_ports_pkg::port_byte_t third_port_oe,
  // fourth port pins (pulled up)
  input  wire parallel_ports_pkg::port_byte_t fourth_port_in,
  output      parallel_ports_pkg::port_byte_t fourth_port_out,
  output      parallel_ports_pkg::port_byte_t fourth_port_oe,
  // spi peripheral
  input  wire logic                          spi_enable,
  input  wire logic                          spi_master,
  input  wire logic                          spi_sclk_out,
  input  wire logic                          spi_mosi_out,
  input  wire logic                          spi_miso_out,
  output      logic                          spi_sclk_in,
  output      logic                          spi_mosi_in,
  output      logic                          spi_miso_in,
  output      logic                          spi_slave_select,
  // timer two
  output      logic                          timer_two_clock_input,
  output      logic                          timer_two_external_control,
  // pulse-width modulator
  input  wire logic                          pwm_enable,
  input  wire logic                          pulse_width_output_a,
  input  wire logic                          pulse_width_output_b,
  output      logic                          pulse_width_ext_clock,
  // uart
  input  wire logic                          uart_enable,
  input  wire logic                          uart_rx_out,
  input  wire logic                          uart_rx_out_en,
  input  wire logic                          uart_tx_out,
  output      logic                          uart_rx_in,
  // interrupts and timer counts
  output      logic                          external_interrupt_zero,
  output      logic                          external_interrupt_one,
  output      logic                          timer_zero_count_input,
  output      logic                          timer_one_count_input
);
  import parallel_ports_pkg::*;

  port_lane_if lane_bus [NUM_PORTS] ();

  port_byte_t pin_raw [NUM_PORTS];
  logic [7:0] port_addr [NUM_PORTS];
  port_byte_t sel_latch;
  port_byte_t sel_pin;
  logic       addr_hit;
  port_byte_t third_level;
  port_byte_t third_alt;
  port_byte_t fourth_alt;
  port_byte_t fourth_level;

  assign pin_raw[LANE_FIRST]  = first_port_in;
  assign pin_raw[LANE_SECOND] = second_port_in;
  assign pin_raw[LANE_THIRD]  = third_port_in;
  assign pin_raw[LANE_FOURTH] = fourth_port_in;

  assign port_addr[LANE_FIRST]  = FIRST_PORT_ADDR;
  assign port_addr[LANE_SECOND] = SECOND_PORT_ADDR;
  assign port_addr[LANE_THIRD]  = THIRD_PORT_ADDR;
  assign port_addr[LANE_FOURTH] = FOURTH_PORT_ADDR;

  // one latch lane per port, decoded from the sfr address
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_lane
    assign lane_bus[p].write_en   = sfr_write && (sfr_addr == port_addr[p]);
    assign lane_bus[p].write_data = sfr_wdata;
    assign lane_bus[p].force_ones = (p == LANE_FIRST) ? xmem_active : 1'b0;
    port_lane u_lane (
      .clk     (clk),
      .reset_n (reset_n),
      .bus     (lane_bus[p]),
      .pin_raw (pin_raw[p])
    );
  end

  // mux the addressed port's latch and pin view
  always_comb begin
    sel_latch = READ_NONE;
    sel_pin   = READ_NONE;
    addr_hit  = 1'b0;
    case (sfr_addr)
      FIRST_PORT_ADDR: begin
        sel_latch = lane_bus[LANE_FIRST].latch;
        sel_pin   = lane_bus[LANE_FIRST].pin_level;
        addr_hit  = 1'b1;
      end
      SECOND_PORT_ADDR: begin
        sel_latch = lane_bus[LANE_SECOND].latch;
        sel_pin   = lane_bus[LANE_SECOND].pin_level;
        addr_hit  = 1'b1;
      end
      THIRD_PORT_ADDR: begin
        sel_latch = lane_bus[LANE_THIRD].latch;
        sel_pin   = lane_bus[LANE_THIRD].pin_level;
        addr_hit  = 1'b1;
      end
      FOURTH_PORT_ADDR: begin
        sel_latch = lane_bus[LANE_FOURTH].latch;
        sel_pin   = lane_bus[LANE_FOURTH].pin_level;
        addr_hit  = 1'b1;
      end
      default: begin
        addr_hit  = 1'b0;
      end
    endcase
  end

  // read data is registered; read-modify-write uses the latch strobe,
  // so a pin loaded low by outside circuitry cannot corrupt the write-back
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata <= READ_NONE;
    end else if (sfr_read_latch && addr_hit) begin
      sfr_rdata <= sel_latch;
    end else if (sfr_read_pin && addr_hit) begin
      sfr_rdata <= sel_pin;
    end else if (sfr_read_latch || sfr_read_pin) begin
      sfr_rdata <= READ_NONE;
    end
  end

  // first port: push-pull bus while accessing with xmem_drive, else open drain
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      first_port_out <= READ_NONE;
      first_port_oe  <= READ_NONE;
    end else if (xmem_active) begin
      first_port_out <= xmem_addr_data;
      first_port_oe  <= xmem_drive ? LATCH_RESET : READ_NONE;
    end else begin
      first_port_out <= READ_NONE;
      first_port_oe  <= ~lane_bus[LANE_FIRST].latch;
    end
  end
  // data coming back from external memory, sampled pins
  assign first_port_to_core = lane_bus[LANE_FIRST].pin_level;

  // second port: selection only, no pin drive exists at all
  assign second_port_analog_sel = lane_bus[LANE_SECOND].latch;

  // third port alternate outputs; enabled peripherals replace the latch
  always_comb begin
    third_alt = lane_bus[LANE_THIRD].latch;
    if (spi_enable) begin
      third_alt[SPI_SCLK_BIT] = spi_master ? spi_sclk_out : 1'b1;
      third_alt[SPI_MOSI_BIT] = spi_master ? spi_mosi_out : 1'b1;
      third_alt[SPI_MISO_BIT] = spi_master ? 1'b1 : spi_miso_out;
    end
    if (pwm_enable) begin
      third_alt[PWM_A_BIT] = pulse_width_output_a;
      third_alt[PWM_B_BIT] = pulse_width_output_b;
    end
  end

  // third port pin drive: upper address driven on every pin during an access, else zero pulls low, one leaves pull-up
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      third_port_out <= READ_NONE;
      third_port_oe  <= READ_NONE;
    end else if (xmem_active) begin
      third_port_out <= xmem_addr_upper;
      third_port_oe  <= LATCH_RESET;
    end else begin
      third_port_out <= READ_NONE;
      third_port_oe  <= ~third_alt;
    end
  end

  // third port inputs to peripherals, from synchronised pins
  assign third_level                = lane_bus[LANE_THIRD].pin_level;
  assign spi_sclk_in                = third_level[SPI_SCLK_BIT];
  assign spi_mosi_in                = third_level[SPI_MOSI_BIT];
  assign spi_miso_in                = third_level[SPI_MISO_BIT];
  assign spi_slave_select           = third_level[SPI_SS_BIT];
  assign timer_two_clock_input      = third_level[SPI_SS_BIT];
  assign timer_two_external_control = third_level[TIMER_TWO_CTRL_BIT];
  assign pulse_width_ext_clock      = third_level[PWM_CLK_BIT];

  // fourth port alternate outputs; a one releases the pin to its pull-up,
  // so an unused or input-only alternate simply stays high
  always_comb begin
    fourth_alt = LATCH_RESET;
    if (uart_enable) begin
      // mode 0 data: the receive pin drives only while the uart asks for it
      fourth_alt[UART_RX_BIT] = uart_rx_out_en ? uart_rx_out : 1'b1;
      fourth_alt[UART_TX_BIT] = uart_tx_out;
    end
    if (xmem_active) begin
      fourth_alt[XWR_BIT] = xmem_write_strobe_n;
      fourth_alt[XRD_BIT] = xmem_read_strobe_n;
    end
  end

  // a zero latch holds the pin low even over an enabled alternate
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fourth_port_out <= READ_NONE;
      fourth_port_oe  <= READ_NONE;
    end else begin
      fourth_port_out <= READ_NONE;
      fourth_port_oe  <= ~(lane_bus[LANE_FOURTH].latch & fourth_alt);
    end
  end

  // fourth port inputs to peripherals
  assign fourth_level            = lane_bus[LANE_FOURTH].pin_level;
  assign uart_rx_in              = fourth_level[UART_RX_BIT];
  assign external_interrupt_zero = fourth_level[EXT_IRQ_ZERO_BIT];
  assign external_interrupt_one  = fourth_level[EXT_IRQ_ONE_BIT];
  assign timer_zero_count_input  = fourth_level[TIMER_ZERO_CNT_BIT];
  assign timer_one_count_input   = fourth_level[TIMER_ONE_CNT_BIT];
endmodule

//--- tb/parallel_ports_properties.sv
// checker bound to the parallel port block's top ports
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
module port_rules
  import parallel_ports_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // sfr side
  input wire logic [7:0] sfr_addr,
  input wire port_byte_t sfr_wdata,
  input wire logic       sfr_write,
  input wire logic       sfr_read_latch,
  input wire port_byte_t sfr_rdata,
  // external access
  input wire logic       xmem_active,
  input wire logic       xmem_drive,
  input wire port_byte_t xmem_addr_data,
  input wire port_byte_t xmem_addr_upper,
  input wire logic       xmem_write_strobe_n,
  input wire logic       xmem_read_strobe_n,
  // pins
  input wire port_byte_t first_port_out,
  input wire port_byte_t first_port_oe,
  input wire port_byte_t second_port_analog_sel,
  input wire port_byte_t third_port_out,
  input wire port_byte_t third_port_oe,
  input wire port_byte_t fourth_port_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // open drain: the first port never drives high outside an access
  property p_first_low;
    !xmem_active && !$past(xmem_active) |-> first_port_out == 8'h00;
  endproperty
  a_first_low: assert property (p_first_low) else $error("first port high");
  // the pad drive lags a write by two edges
  property p_first_write;
    sfr_write && sfr_addr == 8'h80 && !xmem_active ##1 !xmem_active
      |-> ##1 first_port_oe == ~$past(sfr_wdata, 2);
  endproperty
  a_first_write: assert property (p_first_write) else $error("first latch drive");
  property p_bus_drive;
    xmem_active && xmem_drive
      |=> first_port_oe == 8'hff && first_port_out == $past(xmem_addr_data);
  endproperty
  a_bus_drive: assert property (p_bus_drive) else $error("bus not driven");
  // after an access the latch holds ones, so the pads are released
  property p_bus_ones;
    xmem_active ##1 !xmem_active && !sfr_write |=> first_port_oe == 8'h00;
  endproperty
  a_bus_ones: assert property (p_bus_ones) else $error("latch not ones");
  property p_upper;
    xmem_active |=> third_port_oe == 8'hff && third_port_out == $past(xmem_addr_upper);
  endproperty
  a_upper: assert property (p_upper) else $error("upper address");
  property p_fourth_write;
    sfr_write && sfr_addr == 8'hb0 |-> ##2 fourth_port_oe[5:2] == ~$past(sfr_wdata[5:2], 2);
  endproperty
  a_fourth_write: assert property (p_fourth_write) else $error("fourth drive");
  property p_strobes;
    xmem_active && !xmem_read_strobe_n && !xmem_write_strobe_n |=> fourth_port_oe[7:6] == 2'b11;
  endproperty
  a_strobes: assert property (p_strobes) else $error("strobes");
  property p_read_cfg;
    sfr_read_latch && sfr_addr == 8'h90 |=> sfr_rdata == $past(second_port_analog_sel);
  endproperty
  a_read_cfg: assert property (p_read_cfg) else $error("config read");
  c_access: cover property (xmem_active && xmem_drive);
  c_fourth: cover property (sfr_write && sfr_addr == 8'hb0);
  c_read: cover property (sfr_read_latch && sfr_addr == 8'h90);
endmodule

bind parallel_ports port_rules rules_i (.*);

//--- tb/pin_world.sv
// pad model: block drives, pull-ups and an outside driver
// assumes an oe bit high means the block drives that pad
`timescale 1ns/1ps
module pin_world
  import parallel_ports_pkg::*;
(
  // block drives
  input  wire port_byte_t first_port_out,
  input  wire port_byte_t first_port_oe,
  input  wire port_byte_t third_port_out,
  input  wire port_byte_t third_port_oe,
  input  wire port_byte_t fourth_port_out,
  input  wire port_byte_t fourth_port_oe,
  // level of a released pad: pull-up or outside driver
  input  wire port_byte_t ext_level,
  // pad levels back to the block
  output      port_byte_t first_port_in,
  output      port_byte_t second_port_in,
  output      port_byte_t third_port_in,
  output      port_byte_t fourth_port_in
);
  // a driven pad follows the block, a released one the outside level;
  // the level is an argument so the assigns follow a change of it too
  function automatic port_byte_t pad(port_byte_t oe, port_byte_t out, port_byte_t lvl);
    return (oe & out) | (~oe & lvl);
  endfunction
  assign first_port_in  = pad(first_port_oe, first_port_out, ext_level);
  assign second_port_in = ext_level;
  assign third_port_in  = pad(third_port_oe, third_port_out, ext_level);
  assign fourth_port_in = pad(fourth_port_oe, fourth_port_out, ext_level);
endmodule

//--- tb/quad_parallel_io_ports_bench.sv
// self-checking bench for the four-port parallel i/o block
// assumes pin_world resolves every pad from the block's drives
`timescale 1ns/1ps
module quad_parallel_io_ports_bench;
  import parallel_ports_pkg::*;
  typedef struct packed {logic [7:0] a; port_byte_t d, rd, pin;} row_t;
  logic       clk, reset_n, sfr_write, sfr_read_latch, sfr_read_pin, xmem_active;
  logic       xmem_drive, xmem_write_strobe_n, xmem_read_strobe_n, spi_enable, spi_master;
  logic       spi_sclk_out, spi_mosi_out, spi_miso_out, spi_sclk_in, spi_mosi_in;
  logic       spi_miso_in, spi_slave_select, timer_two_clock_input, pwm_enable;
  logic       timer_two_external_control, pulse_width_output_a, pulse_width_output_b;
  logic       pulse_width_ext_clock, uart_enable, uart_rx_out, uart_rx_out_en;
  logic       uart_tx_out, uart_rx_in, external_interrupt_zero, external_interrupt_one;
  logic       timer_zero_count_input, timer_one_count_input;
  logic [7:0] sfr_addr;
  port_byte_t sfr_wdata, sfr_rdata, xmem_addr_data, xmem_addr_upper, ext_level;
  port_byte_t first_port_in, first_port_out, first_port_oe, first_port_to_core;
  port_byte_t second_port_in, second_port_analog_sel, third_port_in, third_port_out;
  port_byte_t third_port_oe, fourth_port_in, fourth_port_out, fourth_port_oe;
  int         failures = 0;
  int         checks_done = 0;
  // released pads sit at 8'h33: pin reads differ from latch reads except in the 8'h88 row and the 8'h00 write to 8'ha0
  row_t       rows [8] = '{'{8'h80, 8'h5a, 8'h5a, 8'h12}, '{8'h90, 8'h0f, 8'h0f, 8'h33},
                           '{8'ha0, 8'hc3, 8'hc3, 8'h03}, '{8'hb0, 8'h3c, 8'h3c, 8'h30},
                           '{8'h88, 8'h77, 8'h00, 8'h00}, '{8'h80, 8'hff, 8'hff, 8'h33},
                           '{8'ha0, 8'h00, 8'h00, 8'h00}, '{8'hb0, 8'hff, 8'hff, 8'h33}};
  // alternate inputs gathered by pin position
  wire port_byte_t third_alt = {pulse_width_ext_clock, 2'b00, timer_two_external_control,
    timer_two_clock_input, spi_miso_in, spi_mosi_in, spi_sclk_in};
  wire port_byte_t fourth_alt = {2'b00, timer_one_count_input, timer_zero_count_input,
    external_interrupt_one, external_interrupt_zero, 1'b0, uart_rx_in};

  parallel_ports uut (.*);
  pin_world      world (.*);

  always #2 clk = ~clk;

  task automatic chk(input string what, input port_byte_t exp, input port_byte_t got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one strobe cycle; op 0 writes, 1 reads latch, 2 reads pins
  task automatic sfr(input int op, input logic [7:0] a, input port_byte_t d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    {sfr_read_pin, sfr_read_latch, sfr_write} = 3'(1 << op);
    @(negedge clk);
    {sfr_read_pin, sfr_read_latch, sfr_write} = 3'b000;
  endtask
  // long enough for the drive register and the two-flop synchroniser
  task automatic settle;
    repeat (4) @(negedge clk);
  endtask
  task automatic hit_reset;
    @(negedge clk);
    reset_n = 1'b0;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      sfr(1, rows[i].a, 8'h00);
      chk("reset latch", 8'hff, sfr_rdata);
    end
    chk("reset oe", 8'h00, first_port_oe);
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    {sfr_write, sfr_read_latch, sfr_read_pin, xmem_active, xmem_drive, pwm_enable} = '0;
    {spi_enable, spi_master, spi_sclk_out, spi_mosi_out, spi_miso_out} = '0;
    {pulse_width_output_a, pulse_width_output_b, uart_enable, uart_rx_out} = '0;
    {uart_rx_out_en, uart_tx_out} = '0;
    {xmem_write_strobe_n, xmem_read_strobe_n} = 2'b11;
    {sfr_addr, sfr_wdata, xmem_addr_data, xmem_addr_upper} = '0;
    ext_level = 8'h33;
    hit_reset();
    // table rows: write, then latch and pin read-back and pad drive
    foreach (rows[i]) begin
      sfr(0, rows[i].a, rows[i].d);
      settle();
      sfr(1, rows[i].a, 8'h00);
      chk("latch", rows[i].rd, sfr_rdata);
      sfr(2, rows[i].a, 8'h00);
      chk("pins", rows[i].pin, sfr_rdata);
      if (rows[i].a == 8'h80) chk("first oe", ~rows[i].d, first_port_oe);
      if (rows[i].a == 8'h90) chk("analog", rows[i].d, second_port_analog_sel);
      if (rows[i].a == 8'ha0) chk("third oe", ~rows[i].d, third_port_oe);
      if (rows[i].a == 8'hb0) chk("fourth oe", ~rows[i].d, fourth_port_oe);
    end
    // external access over a zero latch
    sfr(0, 8'h80, 8'h00);
    {xmem_addr_data, xmem_addr_upper} = 16'ha53c;
    {xmem_active, xmem_drive, xmem_write_strobe_n, xmem_read_strobe_n} = 4'b1100;
    settle();
    chk("bus oe", 8'hff, first_port_oe);
    chk("bus out", 8'ha5, first_port_out);
    chk("bus in", 8'ha5, first_port_to_core);
    chk("upper", 8'h3c, third_port_out);
    chk("upper oe", 8'hff, third_port_oe);
    chk("strobes", 8'hc0, fourth_port_oe);
    xmem_drive = 1'b0;
    settle();
    chk("bus release", 8'h00, first_port_oe);
    {xmem_active, xmem_write_strobe_n, xmem_read_strobe_n} = 3'b011;
    sfr(1, 8'h80, 8'h00);
    chk("latch ones", 8'hff, sfr_rdata);
    // pulse outputs win over a zero latch on bits 5 and 6
    {pwm_enable, pulse_width_output_b, pulse_width_output_a} = 3'b110;
    settle();
    chk("pwm oe", 8'hbf, third_port_oe);
    pwm_enable = 1'b0;
    sfr(0, 8'ha0, 8'hff);
    {spi_enable, spi_master, spi_sclk_out, spi_mosi_out} = 4'b1101;
    settle();
    chk("spi oe", 8'h01, third_port_oe);
    // a slave drives only its data-out pin, here a zero
    spi_master = 1'b0;
    settle();
    chk("spi slave oe", 8'h04, third_port_oe);
    spi_enable = 1'b0;
    // transmit reaches its pin only through a latch one
    {uart_enable, uart_tx_out} = 2'b11;
    sfr(0, 8'hb0, 8'hfd);
    settle();
    chk("tx held low", 8'h02, fourth_port_oe);
    chk("fourth out", 8'h00, fourth_port_out);
    sfr(0, 8'hb0, 8'hff);
    settle();
    chk("tx high", 8'h00, fourth_port_oe);
    uart_tx_out = 1'b0;
    settle();
    chk("tx low", 8'h02, fourth_port_oe);
    // mode 0: the receive pin drives only while its enable is high
    {uart_rx_out_en, uart_tx_out} = 2'b11;
    settle();
    chk("rx drive", 8'h01, fourth_port_oe);
    {uart_enable, uart_rx_out_en} = 2'b00;
    // two complementary pad levels, so every alternate input sees both
    for (int j = 0; j < 2; j++) begin
      ext_level = (j == 0) ? 8'ha5 : 8'h5a;
      settle();
      chk("third alt", (j == 0) ? 8'h85 : 8'h1a, third_alt);
      chk("fourth alt", (j == 0) ? 8'h25 : 8'h18, fourth_alt);
      chk("slave select", (j == 0) ? 8'h00 : 8'h01, {7'h00, spi_slave_select});
    end
    hit_reset();
    end_sim();
  end
endmodule
